// ---- rtl/kmpc_i2c_slave.sv ----
// Serial two-wire register slave with auto-incrementing pointer.
`timescale 1ns/1ps
module kmpc_i2c_slave #(
  parameter logic [6:0] DEV_ADDR = 7'h2a  // Arbitrary value.
) (
  input  wire logic  ref_clk,
  input  wire logic  reset,
  input  wire logic  clk_en,
  input  wire logic  scl_in,
  input  wire logic  sda_in,
  output logic       sda_oe,
  kmpc_reg_if.bus_side rif
);
  import kmpc_pkg::*;

  typedef struct packed {
    kmpc_i2c_state_type st;
    logic               scl_p;
    logic               sda_p;
    logic [7:0]         sh;
    logic [3:0]         cnt;
    logic               rw;
    logic               nack;
    logic [7:0]         ptr;
    logic               oe;
    logic               wr;
  } kmpc_i2c_type;

  localparam kmpc_i2c_type RST = '{st: I2C_IDLE, scl_p: 1'b1, sda_p: 1'b1,
                                   default: '0};
  kmpc_i2c_type q;
  kmpc_i2c_type d;
  logic         rise;
  logic         fall;
  logic         start;
  logic         stop;

  assign rise  = scl_in && !q.scl_p;
  assign fall  = !scl_in && q.scl_p;
  assign start = scl_in && q.scl_p && q.sda_p && !sda_in;
  assign stop  = scl_in && q.scl_p && !q.sda_p && sda_in;

  always_comb begin
    d       = q;
    d.scl_p = scl_in;
    d.sda_p = sda_in;
    d.wr    = 1'b0;
    if (start) begin
      d.st  = I2C_ADDR;
      d.cnt = '0;
    end else if (stop) begin
      d.st = I2C_IDLE;
    end else if (rise) begin
      unique case (q.st)
        I2C_ADDR, I2C_PTR, I2C_WDATA: begin
          d.sh  = {q.sh[6:0], sda_in};
          d.cnt = q.cnt + 4'h1;
        end
        I2C_RDATA_ACK: d.nack = sda_in;
        default: ;
      endcase
    end else if (fall) begin
      unique case (q.st)
        I2C_ADDR: if (q.cnt == FRAME_BITS) begin
          d.rw = q.sh[0];
          d.st = (q.sh[7:1] == DEV_ADDR) ? I2C_ADDR_ACK : I2C_IDLE;
        end
        I2C_PTR: if (q.cnt == FRAME_BITS) begin
          d.ptr = q.sh;
          d.st  = I2C_PTR_ACK;
        end
        I2C_WDATA: if (q.cnt == FRAME_BITS) begin
          d.wr = 1'b1;
          d.st = I2C_WDATA_ACK;
        end
        I2C_ADDR_ACK, I2C_RDATA_ACK: begin
          d.cnt = '0;
          if (q.st == I2C_RDATA_ACK && q.nack) begin
            d.st = I2C_IDLE;
          end else if (q.rw) begin
            // Each byte sent moves the pointer on, so bursts stream.
            d.sh  = rif.rdata;
            d.ptr = q.ptr + 8'h01;
            d.st  = I2C_RDATA;
          end else begin
            d.st = I2C_PTR;
          end
        end
        I2C_PTR_ACK: begin
          d.cnt = '0;
          d.st  = I2C_WDATA;
        end
        I2C_WDATA_ACK: begin
          d.cnt = '0;
          d.ptr = q.ptr + 8'h01;
          d.st  = I2C_WDATA;
        end
        I2C_RDATA: begin
          d.sh  = {q.sh[6:0], 1'b0};
          d.cnt = q.cnt + 4'h1;
          if (q.cnt == FRAME_BITS - 4'h1) begin
            d.st = I2C_RDATA_ACK;
          end
        end
        default: ;
      endcase
    end
    d.oe = (d.st == I2C_ADDR_ACK) || (d.st == I2C_PTR_ACK) ||
           (d.st == I2C_WDATA_ACK) || (d.st == I2C_RDATA && !d.sh[7]);
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      q <= RST;
    end else if (clk_en) begin
      q <= d;
    end
  end

  assign sda_oe    = q.oe;
  assign rif.wr_stb = q.wr;
  assign rif.addr   = q.ptr;
  assign rif.wdata  = q.sh;
endmodule : kmpc_i2c_slave

// ---- rtl/kmpc_pin_cell.sv ----
// Function decode for one matrix line.
`timescale 1ns/1ps
module kmpc_pin_cell #(
  parameter bit HAS_LED = 1'b0
) (
  input  wire logic in_scan,
  input  wire logic dir_out,
  input  wire logic mode_pp,
  input  wire logic led_sel,
  output logic      key_scan,
  output logic      out_en,
  output logic      push_pull,
  output logic      led_drive
);
  // The LED driver wins over the direction bit on lines that have one.
  assign key_scan  = in_scan;
  assign led_drive = HAS_LED && !in_scan && led_sel;
  assign out_en    = !in_scan && !led_drive && dir_out;
  assign push_pull = out_en && mode_pp;
endmodule : kmpc_pin_cell

// ---- rtl/kmpc_pkg.sv ----
// Shared constants and types for the key matrix pin configuration block.
package kmpc_pkg;

  localparam int unsigned BYTE_W = 8;
  localparam int unsigned LINES  = 8;
  localparam int unsigned LEDS   = 4;
  localparam int unsigned LED_LO = 4;

  localparam logic [7:0] ADDR_ARRAY_SIZE = 8'h30;
  localparam logic [7:0] ADDR_LED_SELECT = 8'h31;
  localparam logic [7:0] ADDR_ROW_DIR    = 8'h34;
  localparam logic [7:0] ADDR_COL_DIR    = 8'h35;
  localparam logic [7:0] ADDR_ROW_DRIVE  = 8'h36;
  localparam logic [7:0] ADDR_COL_DRIVE  = 8'h37;

  localparam logic [7:0] RST_ARRAY_SIZE = 8'hff;
  localparam logic [7:0] RST_LED_SELECT = 8'h00;
  localparam logic [7:0] RST_ROW_DIR    = 8'h00;
  localparam logic [7:0] RST_COL_DIR    = 8'h00;
  localparam logic [7:0] RST_ROW_DRIVE  = 8'hff;
  localparam logic [7:0] RST_COL_DRIVE  = 8'h0f;

  // Writable bits of the registers with fixed-zero fields.
  localparam logic [7:0] LED_SELECT_MASK = 8'h0f;
  localparam logic [7:0] COL_DRIVE_MASK  = 8'h0f;

  localparam int unsigned ROW_CODE_LO = 4;
  localparam int unsigned COL_CODE_LO = 0;
  localparam int unsigned ALL_BIT     = 3;

  localparam logic [3:0] FRAME_BITS = 4'h8;
  localparam logic [7:0] READ_IDLE  = 8'h00;

  typedef enum logic [3:0] {
    I2C_IDLE, I2C_ADDR, I2C_ADDR_ACK, I2C_PTR, I2C_PTR_ACK,
    I2C_WDATA, I2C_WDATA_ACK, I2C_RDATA, I2C_RDATA_ACK
  } kmpc_i2c_state_type;

endpackage : kmpc_pkg

// ---- rtl/kmpc_reg_if.sv ----
// Register access path between the serial slave and the register file.
`timescale 1ns/1ps
interface kmpc_reg_if;
  logic       wr_stb;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;

  modport bus_side (output wr_stb, output addr, output wdata, input rdata);
  modport reg_side (input wr_stb, input addr, input wdata, output rdata);
endinterface : kmpc_reg_if

// ---- rtl/kmpc_top.sv ----
// Key matrix pin configuration: register file and per-line function decode.
//
// Overview of operation
// (R1) The row code in the array-size upper nibble enables rows 0 to n-1, and its top bit enables all eight.
// (R2) The column code in the lower nibble enables columns 0 to n-1, and its bit 3 enables all eight.
// (R3) A zero code in either nibble takes all rows or all columns out of key scanning.
// (R4) LED-select bits 3 to 0 pick LED drive for columns 7 to 4, zero meaning GPIO, upper bits reading zero.
// (R5) The row direction register makes row pin n an output when bit n is one and resets to all inputs.
// (R6) The column direction register does the same for columns and resets to all inputs.
// (R7) A drive bit of one gives push-pull and zero open-drain, rows in one register and columns in the other.
// (R8) Columns 7 to 4 are always open-drain and the upper column drive bits ignore writes and stay zero.
// (R9) Lines outside the key array take the GPIO or LED function set by direction, drive and LED select.
`timescale 1ns/1ps
module kmpc_top #(
  parameter logic [6:0] DEV_ADDR = 7'h2a  // Arbitrary value.
) (
  input  wire logic                        ref_clk,
  input  wire logic                        reset,
  input  wire logic                        clk_en,
  input  wire logic                        scl_in,
  input  wire logic                        sda_in,
  output logic                             sda_out,
  output logic                             sda_oe,
  output logic [kmpc_pkg::LINES-1:0]       row_key_scan,
  output logic [kmpc_pkg::LINES-1:0]       col_key_scan,
  output logic [kmpc_pkg::LINES-1:0]       row_out_en,
  output logic [kmpc_pkg::LINES-1:0]       col_out_en,
  output logic [kmpc_pkg::LINES-1:0]       row_push_pull,
  output logic [kmpc_pkg::LINES-1:0]       col_push_pull,
  output logic [kmpc_pkg::LEDS-1:0]        col_led_drive
);
  import kmpc_pkg::*;

  typedef struct packed {
    logic [7:0] array_size;
    logic [7:0] led_select;
    logic [7:0] row_dir;
    logic [7:0] col_dir;
    logic [7:0] row_drive;
    logic [7:0] col_drive;
    logic [7:0] row_key;
    logic [7:0] col_key;
    logic [7:0] row_oe;
    logic [7:0] col_oe;
    logic [7:0] row_pp;
    logic [7:0] col_pp;
    logic [3:0] led_drv;
  } kmpc_top_type;

  // Outputs at reset follow from the reset register values: every line
  // is in the key array, so nothing is driven.
  localparam kmpc_top_type RST = '{
    array_size: RST_ARRAY_SIZE,
    led_select: RST_LED_SELECT,
    row_dir:    RST_ROW_DIR,
    col_dir:    RST_COL_DIR,
    row_drive:  RST_ROW_DRIVE,
    col_drive:  RST_COL_DRIVE,
    row_key:    8'hff,
    col_key:    8'hff,
    default:    '0
  };

  kmpc_top_type q;
  kmpc_top_type d;
  kmpc_reg_if   rif ();
  logic [7:0]   row_span;
  logic [7:0]   col_span;
  logic [7:0]   row_key_c;
  logic [7:0]   col_key_c;
  logic [7:0]   row_oe_c;
  logic [7:0]   col_oe_c;
  logic [7:0]   row_pp_c;
  logic [7:0]   col_pp_c;
  logic [7:0]   row_led_c;
  logic [7:0]   col_led_c;

  // A zero code yields an empty span and the top bit overrides the rest.
  function automatic logic [7:0] kmpc_span(input logic [3:0] code);
    logic [7:0] span;
    span = 8'h00;
    if (code[ALL_BIT]) begin // R1 R2
      span = 8'hff;
    end else begin
      span = (8'h01 << code[2:0]) - 8'h01; // R3
    end
    return span;
  endfunction : kmpc_span

  kmpc_i2c_slave #(
    .DEV_ADDR (DEV_ADDR)
  ) u_i2c (
    .ref_clk (ref_clk),
    .reset   (reset),
    .clk_en  (clk_en),
    .scl_in  (scl_in),
    .sda_in  (sda_in),
    .sda_oe  (sda_oe),
    .rif     (rif.bus_side)
  );

  // The bus line is only ever pulled low; the pad's pull-up makes the one.
  assign sda_out = 1'b0;

  assign row_span = kmpc_span(q.array_size[ROW_CODE_LO +: 4]); // R1
  assign col_span = kmpc_span(q.array_size[COL_CODE_LO +: 4]); // R2

  for (genvar i = 0; i < LINES; i++) begin : g_line
    kmpc_pin_cell #(
      .HAS_LED (1'b0)
    ) u_row (
      .in_scan   (row_span[i]),
      .dir_out   (q.row_dir[i]),
      .mode_pp   (q.row_drive[i]),
      .led_sel   (1'b0),
      .key_scan  (row_key_c[i]),
      .out_en    (row_oe_c[i]),
      .push_pull (row_pp_c[i]),
      .led_drive (row_led_c[i])
    );
    kmpc_pin_cell #(
      .HAS_LED (i >= LED_LO)
    ) u_col (
      .in_scan   (col_span[i]),
      .dir_out   (q.col_dir[i]),
      .mode_pp   (q.col_drive[i]),
      .led_sel   (q.led_select[(i - LED_LO) % LEDS]),
      .key_scan  (col_key_c[i]),
      .out_en    (col_oe_c[i]),
      .push_pull (col_pp_c[i]),
      .led_drive (col_led_c[i])
    );
  end

  always_comb begin
    d = q;
    if (rif.wr_stb) begin
      unique case (rif.addr)
        ADDR_ARRAY_SIZE: d.array_size = rif.wdata; // R1 R2
        ADDR_LED_SELECT: d.led_select = rif.wdata & LED_SELECT_MASK; // R4
        ADDR_ROW_DIR:    d.row_dir    = rif.wdata; // R5
        ADDR_COL_DIR:    d.col_dir    = rif.wdata; // R6
        ADDR_ROW_DRIVE:  d.row_drive  = rif.wdata; // R7
        ADDR_COL_DRIVE:  d.col_drive  = rif.wdata & COL_DRIVE_MASK; // R8
        default: ;
      endcase
    end
    d.row_key = row_key_c; // R9
    d.col_key = col_key_c; // R9
    d.row_oe  = row_oe_c; // R5 R9
    d.col_oe  = col_oe_c; // R6 R9
    d.row_pp  = row_pp_c; // R7
    d.col_pp  = col_pp_c; // R7 R8
    d.led_drv = col_led_c[LINES-1:LED_LO]; // R4
  end

  always_comb begin
    unique case (rif.addr)
      ADDR_ARRAY_SIZE: rif.rdata = q.array_size;
      ADDR_LED_SELECT: rif.rdata = q.led_select;
      ADDR_ROW_DIR:    rif.rdata = q.row_dir;
      ADDR_COL_DIR:    rif.rdata = q.col_dir;
      ADDR_ROW_DRIVE:  rif.rdata = q.row_drive;
      ADDR_COL_DRIVE:  rif.rdata = q.col_drive;
      default:         rif.rdata = READ_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      q <= RST;
    end else if (clk_en) begin
      q <= d;
    end
  end

  assign row_key_scan  = q.row_key;
  assign col_key_scan  = q.col_key;
  assign row_out_en    = q.row_oe;
  assign col_out_en    = q.col_oe;
  assign row_push_pull = q.row_pp;
  assign col_push_pull = q.col_pp;
  assign col_led_drive = q.led_drv;

  AST_ROW_ALL: assert property ( // R1
    @(posedge ref_clk) disable iff (reset)
    clk_en && q.array_size[7] |=> row_key_scan == 8'hff)
    else $error("Row all-scan code did not enable all rows.");

  AST_ROW_SPAN: assert property ( // R1
    @(posedge ref_clk) disable iff (reset)
    clk_en && q.array_size[7:4] == 4'h3 |=> row_key_scan == 8'h07)
    else $error("Row code three did not enable rows zero to two.");

  AST_COL_SPAN: assert property ( // R2
    @(posedge ref_clk) disable iff (reset)
    clk_en && q.array_size[3:0] == 4'h5 |=> col_key_scan == 8'h1f)
    else $error("Column code five did not enable columns zero to four.");

  AST_COL_ALL: assert property ( // R2
    @(posedge ref_clk) disable iff (reset)
    clk_en && q.array_size[3] |=> col_key_scan == 8'hff)
    else $error("Column all-scan code did not enable all columns.");

  AST_ZERO_CODE: assert property ( // R3
    @(posedge ref_clk) disable iff (reset)
    clk_en && q.array_size == 8'h00 |=>
      row_key_scan == 8'h00 && col_key_scan == 8'h00)
    else $error("Zero code left lines in the key array.");

  AST_LED_RESERVED: assert property ( // R4
    @(posedge ref_clk) disable iff (reset)
    q.led_select[7:4] == 4'h0)
    else $error("Reserved LED select bits are not zero.");

  AST_LED_DRIVE: assert property ( // R4
    @(posedge ref_clk) disable iff (reset)
    clk_en && q.led_select[3] && !col_span[7] |=>
      col_led_drive[3] && !col_out_en[7])
    else $error("Column seven did not take the LED function.");

  AST_ROW_DIR: assert property ( // R5
    @(posedge ref_clk) disable iff (reset)
    clk_en |=> row_out_en == ($past(q.row_dir) & ~$past(row_span)))
    else $error("Row output enables do not follow direction and span.");

  AST_COL_DIR_WRITE: assert property ( // R6
    @(posedge ref_clk) disable iff (reset)
    clk_en && rif.wr_stb && rif.addr == ADDR_COL_DIR |=>
      q.col_dir == $past(rif.wdata))
    else $error("Column direction write was not stored.");

  AST_PUSH_PULL: assert property ( // R7
    @(posedge ref_clk) disable iff (reset)
    clk_en && row_oe_c[0] && q.row_drive[0] |=> row_push_pull[0])
    else $error("Row zero output did not go push-pull.");

  AST_OPEN_DRAIN_HIGH: assert property ( // R8
    @(posedge ref_clk) disable iff (reset)
    q.col_drive[7:4] == 4'h0 && col_push_pull[7:4] == 4'h0)
    else $error("Upper columns left open-drain mode.");

  AST_RELEASE: assert property ( // R9
    @(posedge ref_clk) disable iff (reset)
    clk_en && !row_span[2] && q.row_dir[2] ##1 clk_en && $stable(q) |=>
      row_out_en[2] && !row_key_scan[2])
    else $error("Row two outside the array was not released to GPIO.");

  // Register writes land one enabled cycle after the strobe.
  AST_ROW_DIR_WRITE: assert property ( // R5
    @(posedge ref_clk) disable iff (reset)
    clk_en && rif.wr_stb && rif.addr == ADDR_ROW_DIR |=>
      q.row_dir == $past(rif.wdata))
    else $error("Row direction write was not stored.");

  AST_LED_WRITE: assert property ( // R4
    @(posedge ref_clk) disable iff (reset)
    clk_en && rif.wr_stb && rif.addr == ADDR_LED_SELECT |=>
      q.led_select == {4'h0, $past(rif.wdata[3:0])})
    else $error("LED select write did not clear the reserved bits.");

  AST_ROW_DRIVE_WRITE: assert property ( // R7
    @(posedge ref_clk) disable iff (reset)
    clk_en && rif.wr_stb && rif.addr == ADDR_ROW_DRIVE |=>
      q.row_drive == $past(rif.wdata))
    else $error("Row drive write was not stored.");

  AST_COL_DRIVE_WRITE: assert property ( // R8
    @(posedge ref_clk) disable iff (reset)
    clk_en && rif.wr_stb && rif.addr == ADDR_COL_DRIVE |=>
      q.col_drive == {4'h0, $past(rif.wdata[3:0])})
    else $error("Upper column drive bits took a write.");

  AST_COL_DIR: assert property ( // R6
    @(posedge ref_clk) disable iff (reset)
    clk_en |=> col_out_en == ($past(q.col_dir) & ~$past(col_span) &
      ~{$past(q.led_select[3:0]), 4'h0}))
    else $error("Column output enables do not follow direction and span.");

  AST_COL_PUSH_PULL: assert property ( // R7
    @(posedge ref_clk) disable iff (reset)
    clk_en && col_oe_c[1] && q.col_drive[1] |=> col_push_pull[1])
    else $error("Column one output did not go push-pull.");

  AST_OPEN_DRAIN_ROW: assert property ( // R7
    @(posedge ref_clk) disable iff (reset)
    clk_en && row_oe_c[3] && !q.row_drive[3] |=>
      row_out_en[3] && !row_push_pull[3])
    else $error("Row three output did not stay open-drain.");

  AST_ROW_ZERO: assert property ( // R3
    @(posedge ref_clk) disable iff (reset)
    clk_en && q.array_size[7:4] == 4'h0 |=> row_key_scan == 8'h00)
    else $error("Row code zero left rows in the key array.");

  AST_COL_ZERO: assert property ( // R3
    @(posedge ref_clk) disable iff (reset)
    clk_en && q.array_size[3:0] == 4'h0 |=> col_key_scan == 8'h00)
    else $error("Column code zero left columns in the key array.");

  AST_COL_RELEASE: assert property ( // R9
    @(posedge ref_clk) disable iff (reset)
    clk_en && !col_span[6] && !q.led_select[2] && q.col_dir[6] |=>
      col_out_en[6] && !col_key_scan[6])
    else $error("Column six outside the array was not released to GPIO.");

  AST_SCAN_WINS: assert property ( // R9
    @(posedge ref_clk) disable iff (reset)
    clk_en && row_span[1] |=> row_key_scan[1] && !row_out_en[1])
    else $error("Row one in the key array was driven as an output.");

  AST_ROW_ONE: assert property ( // R1
    @(posedge ref_clk) disable iff (reset)
    clk_en && q.array_size[7:4] == 4'h1 |=> row_key_scan == 8'h01)
    else $error("Row code one did not enable row zero alone.");

endmodule : kmpc_top

// ---- verif/key_matrix_pin_config_test.sv ----
// Self-checking bench for the key matrix pin configuration block.
`timescale 1ns/1ps
module key_matrix_pin_config_test;
  import kmpc_pkg::*;
  localparam logic [6:0] DEV = 7'h2a;
  logic        ref_clk, reset, clk_en, scl, sda_line, sda_out, sda_oe;
  logic        rd_valid, snap;
  logic [7:0]  rd_byte, row_key_scan, col_key_scan, row_out_en;
  logic [7:0]  col_out_en, row_push_pull, col_push_pull;
  logic [3:0]  col_led_drive;
  logic [55:0] pins_obs;
  logic [55:0] exp_q[$];
  logic [7:0]  regs[8];
  logic [31:0] lfsr;
  int          err_count, total_checks;

  assign pins_obs = {4'h0, row_key_scan, col_key_scan, row_out_en,
                     col_out_en, row_push_pull, col_push_pull, col_led_drive};

  kmpc_top #(.DEV_ADDR(DEV)) kmpc_top_i (
    .ref_clk(ref_clk), .reset(reset), .clk_en(clk_en), .scl_in(scl),
    .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
    .row_key_scan(row_key_scan), .col_key_scan(col_key_scan),
    .row_out_en(row_out_en), .col_out_en(col_out_en),
    .row_push_pull(row_push_pull), .col_push_pull(col_push_pull),
    .col_led_drive(col_led_drive));

  kmpc_i2c_host kmpc_i2c_host_i (
    .ref_clk(ref_clk), .sda_oe(sda_oe), .sda_out(sda_out), .scl(scl),
    .sda_line(sda_line), .rd_valid(rd_valid), .rd_byte(rd_byte));

  function automatic logic [7:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[7:0];
  endfunction : rnd

  function automatic logic [7:0] span(input logic [3:0] c);
    logic [7:0] s;
    for (int i = 0; i < 8; i++) begin
      s[i] = c[3] || (i < int'(c[2:0]));
    end
    return s;
  endfunction : span

  function automatic logic [55:0] pins_exp();
    logic [7:0] rs, cs, ro, co;
    logic [3:0] led;
    rs = span(regs[0][7:4]);
    cs = span(regs[0][3:0]);
    led = regs[1][3:0] & ~cs[7:4];
    ro = ~rs & regs[4];
    co = ~cs & regs[5] & ~{led, 4'h0};
    return {4'h0, rs, cs, ro, co, ro & regs[6], co & regs[7] & 8'h0f, led};
  endfunction : pins_exp

  task automatic check(input logic [55:0] seen, input logic [55:0] want);
    total_checks++;
    if (seen !== want) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict

  task automatic snap_pins();
    exp_q.push_back(pins_exp());
    snap = 1'b1;
    @(negedge ref_clk);
    snap = 1'b0;
  endtask : snap_pins

  task automatic address(input logic [7:0] ptr);
    logic ack;
    kmpc_i2c_host_i.start();
    kmpc_i2c_host_i.send_byte({DEV, 1'b0}, ack);
    check({55'h0, ack}, 56'h1);
    kmpc_i2c_host_i.send_byte(ptr, ack);
    check({55'h0, ack}, 56'h1);
  endtask : address

  // Unmapped offsets 0x32 and 0x33 sit inside the burst on purpose.
  task automatic write_all(input logic [7:0] size);
    logic       ack;
    logic [7:0] d;
    address(ADDR_ARRAY_SIZE);
    for (int i = 0; i < 8; i++) begin
      d = (i == 0) ? size : rnd();
      kmpc_i2c_host_i.send_byte(d, ack);
      check({55'h0, ack}, 56'h1);
      if (i != 2 && i != 3) begin
        regs[i] = d & ((i == 1 || i == 7) ? 8'h0f : 8'hff);
      end
    end
    kmpc_i2c_host_i.stop();
  endtask : write_all

  task automatic read_all();
    logic ack;
    address(ADDR_ARRAY_SIZE);
    kmpc_i2c_host_i.start();
    kmpc_i2c_host_i.send_byte({DEV, 1'b1}, ack);
    check({55'h0, ack}, 56'h1);
    for (int i = 0; i < 8; i++) begin
      exp_q.push_back({48'h0, regs[i]});
      kmpc_i2c_host_i.recv_byte(i == 7);
    end
    kmpc_i2c_host_i.stop();
  endtask : read_all

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    if (rd_valid || snap) begin
      if (exp_q.size() == 0) begin
        check(56'h1, 56'h0);
      end else begin
        check(snap ? pins_obs : {48'h0, rd_byte}, exp_q.pop_front());
      end
    end
  end

  initial begin
    repeat (40000) @(posedge ref_clk);
    err_count++;
    give_verdict();
  end

  initial begin
    logic ack;
    reset = 1'b1;
    clk_en = 1'b1;
    snap = 1'b0;
    lfsr = 32'hbf2754a5;
    err_count = 0;
    total_checks = 0;
    for (int r = 0; r < 2; r++) begin
      regs = '{8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h0f};
      repeat (10) @(negedge ref_clk);
      reset = 1'b0;
      @(negedge ref_clk);
      snap_pins();
      read_all();
      // Row codes walk 0 to 9 while column codes walk 9 down to 0; the
      // last pass clears both nibbles at once.
      for (int c = 0; c < 11 && r == 0; c++) begin
        write_all((c == 10) ? 8'h00 : {4'(c), 4'(9 - c)});
        snap_pins();
        read_all();
        if (c == 4) begin
          kmpc_i2c_host_i.start();
          kmpc_i2c_host_i.send_byte({DEV ^ 7'h01, 1'b0}, ack);
          check({55'h0, ack}, 56'h0);
          kmpc_i2c_host_i.stop();
          // With the enable low the slave sees no edges, so nothing lands.
          clk_en = 1'b0;
          kmpc_i2c_host_i.start();
          kmpc_i2c_host_i.send_byte({DEV, 1'b0}, ack);
          check({55'h0, ack}, 56'h0);
          kmpc_i2c_host_i.send_byte(ADDR_ROW_DIR, ack);
          kmpc_i2c_host_i.send_byte(~regs[4], ack);
          kmpc_i2c_host_i.stop();
          clk_en = 1'b1;
          read_all();
          snap_pins();
        end
      end
      reset = 1'b1;
    end
    repeat (4) @(negedge ref_clk);
    give_verdict();
  end
endmodule : key_matrix_pin_config_test

// ---- verif/kmpc_i2c_host.sv ----
// Two-wire bus master that stands in for the host processor.
`timescale 1ns/1ps
module kmpc_i2c_host (
  input  wire logic  ref_clk,
  input  wire logic  sda_oe,
  input  wire logic  sda_out,
  output logic       scl,
  output logic       sda_line,
  output logic       rd_valid,
  output logic [7:0] rd_byte
);
  logic host_sda;

  // The data line has a pull-up: it reads high unless someone pulls it low.
  assign sda_line = host_sda & (sda_oe ? sda_out : 1'b1);

  initial begin
    scl = 1'b1;
    host_sda = 1'b1;
    rd_valid = 1'b0;
    rd_byte = 8'h00;
  end

  // Two device clocks per bus phase keeps to the slave's minimum.
  task automatic half();
    repeat (2) @(negedge ref_clk);
  endtask : half

  task automatic start();
    host_sda = 1'b1;
    half();
    scl = 1'b1;
    half();
    host_sda = 1'b0;
    half();
    scl = 1'b0;
    half();
  endtask : start

  task automatic stop();
    host_sda = 1'b0;
    half();
    scl = 1'b1;
    half();
    host_sda = 1'b1;
    half();
  endtask : stop

  task automatic clock_bit(input logic b, output logic seen);
    host_sda = b;
    half();
    scl = 1'b1;
    half();
    seen = sda_line;
    scl = 1'b0;
    half();
  endtask : clock_bit

  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic seen;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(b[i], seen);
    end
    clock_bit(1'b1, seen);
    ack = ~seen;
  endtask : send_byte

  task automatic recv_byte(input logic last);
    logic [7:0] b;
    logic       seen;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(1'b1, seen);
      b[i] = seen;
    end
    rd_byte = b;
    rd_valid = 1'b1;
    @(negedge ref_clk);
    rd_valid = 1'b0;
    clock_bit(last, seen);
  endtask : recv_byte
endmodule : kmpc_i2c_host
